//--- core/psq_pkg.sv
// Shared constants and types for the program sequencer block.
package psq_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_OFFSET_PTR = 8'h83;
  localparam logic [7:0] IDX_BANK_PTR   = 8'h84;
  localparam logic [7:0] IDX_IP_LOW     = 8'h90;
  localparam logic [7:0] IDX_IP_HIGH    = 8'h91;
  localparam logic [7:0] IDX_WORK       = 8'h92;
  localparam logic [7:0] IDX_MEM_OPND   = 8'h93;
  localparam logic [7:0] IDX_FLAGS      = 8'h94;
  localparam logic [7:0] IDX_TABLE_HI   = 8'h95;
  localparam logic [7:0] IDX_OP         = 8'h96;

  // Values after reset.
  localparam logic [9:0] IP_RESET   = 10'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Flag bit positions within the flags register.
  localparam int unsigned FLAG_Z_POS  = 0;
  localparam int unsigned FLAG_DC_POS = 1;
  localparam int unsigned FLAG_C_POS  = 2;

  // Sequencer steps in instruction words.
  localparam logic [9:0] IP_STEP      = 10'h001;
  localparam logic [9:0] IP_SKIP_STEP = 10'h002;

  // Operation codes written to the operation register.
  typedef enum logic [4:0] {
    PSQ_OP_STEP      = 5'h00,
    PSQ_OP_JUMP      = 5'h01,
    PSQ_OP_CALL      = 5'h02,
    PSQ_OP_CMP_IMM   = 5'h03,
    PSQ_OP_CMP_MEM   = 5'h04,
    PSQ_OP_INC_ACC   = 5'h05,
    PSQ_OP_INC_MEM   = 5'h06,
    PSQ_OP_DEC_ACC   = 5'h07,
    PSQ_OP_DEC_MEM   = 5'h08,
    PSQ_OP_BIT_CLR   = 5'h09,
    PSQ_OP_BIT_SET   = 5'h0A,
    PSQ_OP_B0BIT_CLR = 5'h0B,
    PSQ_OP_B0BIT_SET = 5'h0C,
    PSQ_OP_ADD_LOW   = 5'h0D,
    PSQ_OP_ADC_LOW   = 5'h0E,
    PSQ_OP_BANK0_ADD_OP_LOW = 5'h0F,
    PSQ_OP_SUB_LOW   = 5'h10,
    PSQ_OP_TABLE_RD  = 5'h11,
    PSQ_OP_IRQ_ENTER = 5'h12
  } psq_opcode_t;

  // Operation word, carried in write data bits 25..0.
  typedef struct packed {
    logic [9:0]  dest;
    logic [7:0]  imm;
    logic [2:0]  bitsel;
    psq_opcode_t code;
  } psq_op_t;

  // Arithmetic flags in register order.
  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } psq_flags_t;

endpackage

//--- core/psq_sequencer.sv
// Program sequencer, flags and pointer registers behind a Wishbone slave.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module psq_sequencer (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [9:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic [15:0] i_rom_data,
  output logic      [9:0]  o_fetch_addr,
  output logic      [15:0] o_ram_addr,
  output logic      [15:0] o_rom_addr,
  output logic             o_push_valid,
  output logic      [9:0]  o_push_addr
);

  logic [9:0]           ip_q;
  logic [7:0]           bank_q;
  logic [7:0]           offset_q;
  logic [7:0]           work_q;
  logic [7:0]           mem_q;
  logic [7:0]           table_hi_q;
  psq_pkg::psq_flags_t  flags_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;
  logic                 push_q;
  logic [9:0]           push_addr_q;
  logic [31:0]          rd_mux;

  // Bus decode: a write lands on the edge at which the master sees ack.
  wire  [7:0]     idx      = i_wb_adr[9:2];
  wire            bus_req  = i_wb_cyc & i_wb_stb;
  wire            wr_hit   = bus_req & i_wb_we & ack_q;
  wire            byte_wr  = wr_hit & i_wb_sel[0];
  wire            op_go    = wr_hit & (&i_wb_sel) & (idx == psq_pkg::IDX_OP);
  psq_pkg::psq_op_t op;
  assign op = psq_pkg::psq_op_t'(i_wb_dat[25:0]);

  // Sequential successors of the current pointer.
  wire  [9:0]     ip_inc   = ip_q + psq_pkg::IP_STEP;
  wire  [9:0]     ip_skip  = ip_q + psq_pkg::IP_SKIP_STEP;

  // The low byte is added to after the step, so an addend of zero lands on
  // the very next word, as a jump table expects.
  wire            add_cin  = (op.code == psq_pkg::PSQ_OP_ADC_LOW) & flags_q.c;
  wire  [8:0]     add_sum  = {1'b0, ip_inc[7:0]} + {1'b0, work_q}
                             + {8'h00, add_cin};
  wire  [4:0]     add_nib  = {1'b0, ip_inc[3:0]} + {1'b0, work_q[3:0]}
                             + {4'h0, add_cin};
  wire  [1:0]     add_high = ip_inc[9:8] + {1'b0, add_sum[8]};
  wire  [8:0]     sub_res  = {1'b0, ip_inc[7:0]} - {1'b0, work_q};
  wire            sub_dc   = ip_inc[3:0] >= work_q[3:0];

  // Compare, increment, decrement and bit-test terms.
  wire  [7:0]     cmp_b    = (op.code == psq_pkg::PSQ_OP_CMP_MEM) ? mem_q
                                                                  : op.imm;
  wire            cmp_eq   = work_q == cmp_b;
  wire            cmp_ge   = work_q >= cmp_b;
  wire            cmp_dc   = work_q[3:0] >= cmp_b[3:0];
  wire  [7:0]     acc_inc  = work_q + 8'h01;
  wire  [7:0]     acc_dec  = work_q - 8'h01;
  wire  [7:0]     mem_inc  = mem_q + 8'h01;
  wire  [7:0]     mem_dec  = mem_q - 8'h01;
  wire            bit_val  = mem_q[op.bitsel];

  logic [9:0]           ip_x;
  logic [7:0]           work_x;
  logic [7:0]           mem_x;
  logic [7:0]           th_x;
  psq_pkg::psq_flags_t  flags_x;
  logic                 push_x;
  logic [9:0]           paddr_x;
  logic                 skip_x;

  // Result of one operation; a skip only bypasses the next word.
  always_comb
  begin
    ip_x    = ip_inc;
    work_x  = work_q;
    mem_x   = mem_q;
    th_x    = table_hi_q;
    flags_x = flags_q;
    push_x  = 1'b0;
    paddr_x = ip_inc;
    skip_x  = 1'b0;
    case (op.code)
      psq_pkg::PSQ_OP_JUMP: ip_x = op.dest;
      psq_pkg::PSQ_OP_CALL:
      begin
        ip_x   = op.dest;
        push_x = 1'b1;
      end
      psq_pkg::PSQ_OP_IRQ_ENTER:
      begin
        ip_x    = op.dest;
        push_x  = 1'b1;
        paddr_x = ip_q;
      end
      psq_pkg::PSQ_OP_CMP_IMM, psq_pkg::PSQ_OP_CMP_MEM:
      begin
        skip_x     = cmp_eq;
        flags_x.z  = cmp_eq;
        flags_x.c  = cmp_ge;
        flags_x.dc = cmp_dc;
      end
      psq_pkg::PSQ_OP_INC_ACC:
      begin
        work_x = acc_inc;
        skip_x = acc_inc == 8'h00;
      end
      psq_pkg::PSQ_OP_INC_MEM:
      begin
        mem_x  = mem_inc;
        skip_x = mem_inc == 8'h00;
      end
      psq_pkg::PSQ_OP_DEC_ACC:
      begin
        work_x = acc_dec;
        skip_x = acc_dec == 8'h00;
      end
      psq_pkg::PSQ_OP_DEC_MEM:
      begin
        mem_x  = mem_dec;
        skip_x = mem_dec == 8'h00;
      end
      psq_pkg::PSQ_OP_BIT_CLR, psq_pkg::PSQ_OP_B0BIT_CLR:
        skip_x = ~bit_val;
      psq_pkg::PSQ_OP_BIT_SET, psq_pkg::PSQ_OP_B0BIT_SET:
        skip_x = bit_val;
      psq_pkg::PSQ_OP_ADD_LOW, psq_pkg::PSQ_OP_ADC_LOW,
      psq_pkg::PSQ_OP_BANK0_ADD_OP_LOW:
      begin
        ip_x       = {add_high, add_sum[7:0]};
        flags_x.c  = add_sum[8];
        flags_x.dc = add_nib[4];
        flags_x.z  = add_sum[7:0] == 8'h00;
      end
      psq_pkg::PSQ_OP_SUB_LOW:
      begin
        ip_x       = {ip_inc[9:8], sub_res[7:0]};
        flags_x.c  = ~sub_res[8];
        flags_x.dc = sub_dc;
        flags_x.z  = sub_res[7:0] == 8'h00;
      end
      psq_pkg::PSQ_OP_TABLE_RD:
      begin
        th_x   = i_rom_data[15:8];
        work_x = i_rom_data[7:0];
      end
      default: ip_x = ip_inc;
    endcase
    if (skip_x)
      ip_x = ip_skip;
  end

  // Bus handshake: ack rises one cycle after the request and drops after.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req & ~ack_q;
  end

  // Read data is captured with ack; unmapped indices read as zero.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdat_q <= 32'h0000_0000;
    else if (bus_req & ~ack_q)
      rdat_q <= rd_mux;
  end

  // Register read selection; bits above a register's width read as zero.
  always_comb
  begin
    case (idx)
      psq_pkg::IDX_OFFSET_PTR: rd_mux = {24'h000000, offset_q};
      psq_pkg::IDX_BANK_PTR:   rd_mux = {24'h000000, bank_q};
      psq_pkg::IDX_IP_LOW:     rd_mux = {24'h000000, ip_q[7:0]};
      psq_pkg::IDX_IP_HIGH:    rd_mux = {30'h00000000, ip_q[9:8]};
      psq_pkg::IDX_WORK:       rd_mux = {24'h000000, work_q};
      psq_pkg::IDX_MEM_OPND:   rd_mux = {24'h000000, mem_q};
      psq_pkg::IDX_FLAGS:      rd_mux = {29'h00000000, flags_q};
      psq_pkg::IDX_TABLE_HI:   rd_mux = {24'h000000, table_hi_q};
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // Pointer state: an operation wins over a plain register write.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ip_q <= psq_pkg::IP_RESET;
    else if (op_go)
      ip_q <= ip_x;
    else if (byte_wr & (idx == psq_pkg::IDX_IP_LOW))
      ip_q <= {ip_q[9:8], i_wb_dat[7:0]};
    else if (byte_wr & (idx == psq_pkg::IDX_IP_HIGH))
      ip_q <= {i_wb_dat[1:0], ip_q[7:0]};
  end

  // Data registers touched by operations or by software writes.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      work_q     <= psq_pkg::BYTE_RESET;
      mem_q      <= psq_pkg::BYTE_RESET;
      table_hi_q <= psq_pkg::BYTE_RESET;
      flags_q    <= '0;
    end
    else if (op_go)
    begin
      work_q     <= work_x;
      mem_q      <= mem_x;
      table_hi_q <= th_x;
      flags_q    <= flags_x;
    end
    else if (byte_wr)
    begin
      if (idx == psq_pkg::IDX_WORK)
        work_q <= i_wb_dat[7:0];
      if (idx == psq_pkg::IDX_MEM_OPND)
        mem_q <= i_wb_dat[7:0];
      if (idx == psq_pkg::IDX_TABLE_HI)
        table_hi_q <= i_wb_dat[7:0];
      if (idx == psq_pkg::IDX_FLAGS)
        flags_q <= psq_pkg::psq_flags_t'(i_wb_dat[2:0]);
    end
  end

  // The two pointers are ordinary storage as well as address sources.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bank_q   <= psq_pkg::BYTE_RESET;
      offset_q <= psq_pkg::BYTE_RESET;
    end
    else if (byte_wr)
    begin
      if (idx == psq_pkg::IDX_BANK_PTR)
        bank_q <= i_wb_dat[7:0];
      if (idx == psq_pkg::IDX_OFFSET_PTR)
        offset_q <= i_wb_dat[7:0];
    end
  end

  // Return-stack push strobe stands for exactly one cycle.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      push_q      <= 1'b0;
      push_addr_q <= psq_pkg::IP_RESET;
    end
    else
    begin
      push_q <= op_go & push_x;
      if (op_go & push_x)
        push_addr_q <= paddr_x;
    end
  end

  // Outputs; the address pair comes straight from the pointer flops.
  assign o_wb_ack     = ack_q;
  assign o_wb_dat     = rdat_q;
  assign o_fetch_addr = ip_q;
  assign o_ram_addr   = {bank_q, offset_q};
  assign o_rom_addr   = {bank_q, offset_q};
  assign o_push_valid = push_q;
  assign o_push_addr  = push_addr_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_cmp_skip_two: assert property (op_go && work_q == op.imm
    && op.code == psq_pkg::PSQ_OP_CMP_IMM |=> ip_q == $past(ip_q) + 10'h002)
    else $error("compare match did not skip");
  a_cmp_no_skip: assert property (op_go && work_q != op.imm
    && op.code == psq_pkg::PSQ_OP_CMP_IMM |=> ip_q == $past(ip_q) + 10'h001)
    else $error("compare mismatch did not step by one");
  a_jump_loads: assert property (op_go
    && op.code == psq_pkg::PSQ_OP_JUMP |=> ip_q == $past(op.dest))
    else $error("jump did not load destination");
  a_call_push: assert property (op_go
    && op.code == psq_pkg::PSQ_OP_CALL |=> o_push_valid
    && o_push_addr == $past(ip_inc) ##1 !o_push_valid)
    else $error("call push wrong");
  a_low_carry: assert property (op_go && add_sum[8]
    && op.code == psq_pkg::PSQ_OP_ADD_LOW
    |=> ip_q[9:8] == $past(ip_inc[9:8]) + 2'h1)
    else $error("low byte carry lost");
  a_borrow_kept: assert property (op_go
    && op.code == psq_pkg::PSQ_OP_SUB_LOW |=> ip_q[9:8] == $past(ip_inc[9:8]))
    else $error("borrow changed high part");
  a_low_write: assert property (byte_wr && !op_go
    && idx == psq_pkg::IDX_IP_LOW
    |=> ip_q == {$past(ip_q[9:8]), $past(i_wb_dat[7:0])})
    else $error("low byte write wrong");
  a_zero_flag: assert property (op_go
    && op.code == psq_pkg::PSQ_OP_ADD_LOW |=> flags_q.z == ~|ip_q[7:0])
    else $error("zero flag wrong");
  a_table_split: assert property (op_go
    && op.code == psq_pkg::PSQ_OP_TABLE_RD |=> work_q == $past(i_rom_data[7:0])
    && table_hi_q == $past(i_rom_data[15:8]))
    else $error("table read split wrong");
  a_bit_set_skip: assert property (op_go && bit_val
    && op.code == psq_pkg::PSQ_OP_BIT_SET |=> ip_q == $past(ip_q) + 10'h002
    && mem_q == $past(mem_q))
    else $error("bit set test did not skip");

endmodule

//--- testbench/program_sequencer_and_pointers_bench.sv
// Self-checking bench for the program sequencer and pointer registers.
`timescale 1ns/1ps
module program_sequencer_and_pointers_bench;
  logic        i_clk;
  logic        i_resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        o_push_valid;
  logic [15:0] rom;
  logic [15:0] o_ram_addr;
  logic [15:0] o_rom_addr;
  logic [9:0]  o_fetch_addr;
  logic [9:0]  o_push_addr;
  logic [9:0]  eip;
  logic [9:0]  pv;
  logic [31:0] q;
  logic [7:0]  w;
  logic [7:0]  m;
  logic [7:0]  im;
  logic [7:0]  v;
  logic [8:0]  s;
  logic [2:0]  efl;
  logic [2:0]  bs;
  logic        cin;
  logic        sk;
  int          err_count;
  int          comparisons;
  int          seed;
  int          pc = 0;
  int          n0;
  int          i;
  psq_pkg::psq_opcode_t code;

  psq_sequencer uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_rom_data(rom), .o_fetch_addr(o_fetch_addr), .o_ram_addr(o_ram_addr),
    .o_rom_addr(o_rom_addr), .o_push_valid(o_push_valid),
    .o_push_addr(o_push_addr));

  // Free-running core clock, 8 ns period.
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Pushes are counted as they pass, so a one-cycle pulse is never missed.
  always @(posedge i_clk)
    if (o_push_valid === 1'b1)
    begin
      pc <= pc + 1;
      pv <= o_push_addr;
    end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One classic cycle: the request stands until the rising edge at which
  // ack is seen high; read data is taken and the request dropped there.
  // The slave answers in the cycle after it takes the request.
  task wb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
          input logic [3:0] bsel);
    int n;
    @(posedge i_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr;
    adr  <= {idx, 2'b00};
    sel  <= bsel;
    wdat <= d;
    @(posedge i_clk);
    n = 1;
    while (o_wb_ack !== 1'b1)
    begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(n), 32'h0000_0002);
    q = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d, 4'hF);
  endtask

  task rd(input logic [7:0] idx);
    wb(1'b0, idx, 32'h0000_0000, 4'hF);
  endtask

  task op(input psq_pkg::psq_opcode_t c, input logic [9:0] d,
          input logic [7:0] b, input logic [2:0] bit_i);
    wr(psq_pkg::IDX_OP, {6'h00, d, b, bit_i, c});
  endtask

  task chk_ip(input logic [9:0] e);
    rd(psq_pkg::IDX_IP_LOW);
    chk(q, {24'h000000, e[7:0]});
    rd(psq_pkg::IDX_IP_HIGH);
    chk(q, {30'h00000000, e[9:8]});
    chk({22'h000000, o_fetch_addr}, {22'h000000, e});
  endtask

  task chk_fl;
    rd(psq_pkg::IDX_FLAGS);
    chk(q, {29'h00000000, efl});
  endtask

  // Skip decision of the ten skipping operations.
  function automatic logic skip_of(psq_pkg::psq_opcode_t c, logic [7:0] a,
                                   logic [7:0] b, logic [7:0] k,
                                   logic [2:0] p);
    case (c)
      psq_pkg::PSQ_OP_CMP_IMM: return a == k;
      psq_pkg::PSQ_OP_CMP_MEM: return a == b;
      psq_pkg::PSQ_OP_INC_ACC: return a == 8'hFF;
      psq_pkg::PSQ_OP_INC_MEM: return b == 8'hFF;
      psq_pkg::PSQ_OP_DEC_ACC: return a == 8'h01;
      psq_pkg::PSQ_OP_DEC_MEM: return b == 8'h01;
      psq_pkg::PSQ_OP_BIT_CLR, psq_pkg::PSQ_OP_B0BIT_CLR: return !b[p];
      default: return b[p];
    endcase
  endfunction

  // A hang ends the run as a failure.
  initial
  begin
    #100000;
    err_count++;
    end_of_test;
  end

  initial
  begin
    {cyc, stb, we, adr, sel, wdat, rom} = '0;
    {err_count, comparisons, efl, eip} = '0;
    seed = 65684;
    i_resetn = 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk_ip(10'h000);
    rd(psq_pkg::IDX_BANK_PTR);
    chk(q, 32'h0000_0000);
    rd(8'h00);
    chk(q, 32'h0000_0000);
    // Pointers, a write lacking byte lane 0, an unmapped write, table reads.
    for (i = 0; i < 4; i++)
    begin
      w = 8'($random(seed));
      m = 8'($random(seed));
      wr(psq_pkg::IDX_BANK_PTR, {24'h000000, w});
      wr(psq_pkg::IDX_OFFSET_PTR, {24'h000000, m});
      wb(1'b1, psq_pkg::IDX_OFFSET_PTR, {24'h000000, ~m}, 4'hE);
      wr(8'h00, 32'hFFFF_FFFF);
      rd(psq_pkg::IDX_BANK_PTR);
      chk(q, {24'h000000, w});
      rd(psq_pkg::IDX_OFFSET_PTR);
      chk(q, {24'h000000, m});
      chk({16'h0000, o_ram_addr}, {16'h0000, w, m});
      chk({16'h0000, o_rom_addr}, {16'h0000, w, m});
      rom <= 16'($random(seed));
      op(psq_pkg::PSQ_OP_TABLE_RD, 10'h000, 8'h00, 3'h0);
      eip = eip + 10'h001;
      rd(psq_pkg::IDX_WORK);
      chk(q, {24'h000000, rom[7:0]});
      rd(psq_pkg::IDX_TABLE_HI);
      chk(q, {24'h000000, rom[15:8]});
    end
    op(psq_pkg::PSQ_OP_STEP, 10'h3FF, 8'h00, 3'h0);
    eip = eip + 10'h001;
    chk_ip(eip);
    // Jump, call and interrupt entry; only the last two push.
    for (i = 0; i < 3; i++)
    begin
      code = (i == 0) ? psq_pkg::PSQ_OP_JUMP :
             (i == 1) ? psq_pkg::PSQ_OP_CALL : psq_pkg::PSQ_OP_IRQ_ENTER;
      v = 8'($random(seed));
      n0 = pc;
      op(code, {2'(i + 1), v}, 8'h00, 3'h0);
      repeat (2) @(posedge i_clk);
      chk(32'(pc), 32'(n0 + (i > 0)));
      if (i > 0)
        chk({22'h0, pv}, {22'h0, (i == 1) ? eip + 10'h001 : eip});
      eip = {2'(i + 1), v};
      chk_ip(eip);
    end
    // Skipping operations with wrap and bit-level corners mixed in.
    for (i = 0; i < 48; i++)
    begin
      code = psq_pkg::psq_opcode_t'(5'h03 + 5'(i % 10));
      v = ((i / 10) % 4 == 0) ? 8'hFF : ((i / 10) % 4 == 1) ? 8'h01 :
          ((i / 10) % 4 == 2) ? 8'h00 : 8'($random(seed));
      w = v;
      m = (i % 7 == 0) ? 8'($random(seed)) : v;
      im = (i % 8 < 4) ? v : 8'($random(seed));
      bs = 3'($random(seed));
      wr(psq_pkg::IDX_WORK, {24'h000000, w});
      wr(psq_pkg::IDX_MEM_OPND, {24'h000000, m});
      op(code, 10'h000, im, bs);
      sk = skip_of(code, w, m, im, bs);
      v = (code == psq_pkg::PSQ_OP_CMP_IMM) ? im : m;
      if (code == psq_pkg::PSQ_OP_CMP_IMM || code == psq_pkg::PSQ_OP_CMP_MEM)
        efl = {w >= v, w[3:0] >= v[3:0], w == v};
      w = w + 8'(code == psq_pkg::PSQ_OP_INC_ACC)
            - 8'(code == psq_pkg::PSQ_OP_DEC_ACC);
      m = m + 8'(code == psq_pkg::PSQ_OP_INC_MEM)
            - 8'(code == psq_pkg::PSQ_OP_DEC_MEM);
      eip = eip + (sk ? psq_pkg::IP_SKIP_STEP : psq_pkg::IP_STEP);
      chk_ip(eip);
      chk_fl;
      rd(psq_pkg::IDX_WORK);
      chk(q, {24'h000000, w});
      rd(psq_pkg::IDX_MEM_OPND);
      chk(q, {24'h000000, m});
    end
    // Arithmetic into the low byte: carries reach the high part, borrows not.
    for (i = 0; i < 32; i++)
    begin
      code = (i % 4 == 0) ? psq_pkg::PSQ_OP_ADD_LOW :
             (i % 4 == 1) ? psq_pkg::PSQ_OP_ADC_LOW :
             (i % 4 == 2) ? psq_pkg::PSQ_OP_BANK0_ADD_OP_LOW : psq_pkg::PSQ_OP_SUB_LOW;
      eip = 10'($random(seed));
      w = 8'($random(seed));
      op(psq_pkg::PSQ_OP_JUMP, eip, 8'h00, 3'h0);
      wr(psq_pkg::IDX_WORK, {24'h000000, w});
      op(code, 10'h000, 8'h00, 3'h0);
      eip = eip + 10'h001;
      cin = (code == psq_pkg::PSQ_OP_ADC_LOW) & efl[2];
      if (code == psq_pkg::PSQ_OP_SUB_LOW)
      begin
        s = {1'b0, eip[7:0]} - {1'b0, w};
        efl = {!s[8], eip[3:0] >= w[3:0], s[7:0] == 8'h00};
        eip[7:0] = s[7:0];
      end
      else
      begin
        s = eip[7:0] + w + cin;
        efl = {s[8], 5'(eip[3:0]) + w[3:0] + cin > 5'h0F, s[7:0] == 8'h00};
        eip = {eip[9:8] + 2'(s[8]), s[7:0]};
      end
      chk_ip(eip);
      chk_fl;
    end
    op(psq_pkg::PSQ_OP_JUMP, 10'h323, 8'h00, 3'h0);
    wr(psq_pkg::IDX_IP_LOW, 32'h0000_0028);
    chk_ip(10'h328);
    wr(psq_pkg::IDX_IP_LOW, 32'h0000_0000);
    chk_ip(10'h300);
    // A second reset in mid-run must bring fetching back to zero.
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk_ip(10'h000);
    end_of_test;
  end
endmodule
